// ==== shared/ssr_pkg.sv ====
// Shared constants for the serial result readout block
package ssr_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL     = 8'h00; // Control
    localparam logic [7:0]  ADDR_RESULT   = 8'h04; // Next conversion result
    localparam logic [7:0]  ADDR_CONV     = 8'h08; // Conversion length
    localparam logic [7:0]  ADDR_STATUS   = 8'h0c; // Port status
    localparam logic [7:0]  ADDR_LAST     = 8'h10; // Last completed result
    localparam logic [2:0]  IDX_NONE      = 3'h7;  // Unmapped address
    // ==========================================
    // Field positions
    localparam int          CTRL_ENABLE   = 0;     // Conversion engine enable
    localparam int          ST_BUSY       = 0;     // Conversion running
    localparam int          ST_INCOMPLETE = 1;     // Sticky incomplete read, W1C
    localparam int          ST_SELECTED   = 2;     // Port selected
    localparam int          ST_DURING     = 3;     // Read during conversion
    localparam int          ST_COUNT_LSB  = 8;     // Bit count field
    // ==========================================
    // Reset values and timing
    localparam logic        CTRL_RESET    = 1'b1;         // Engine on
    localparam int          CLK_NS        = 10;           // aclk period
    localparam int          CONV_TIME_NS  = 4000;         // Default conversion time
    localparam logic [15:0] CONV_RESET    = 16'(CONV_TIME_NS / CLK_NS);
    localparam logic [4:0]  WORD_BITS     = 5'h10;        // Result width
    localparam logic [1:0]  RESP_OKAY     = 2'h0;         // AXI OKAY
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;         // AXI SLVERR
    // ==========================================
    // Synchronised pin indexes
    localparam int          PIN_SCLK      = 0;
    localparam int          PIN_CS_N      = 1;
    localparam int          PIN_RD_N      = 2;
    localparam int          PIN_CHAIN     = 3;
    localparam int          PIN_CNV_N     = 4;
    localparam int          PIN_EXT       = 5;
    localparam int          PIN_SER       = 6;
    localparam int          PIN_COUNT     = 7;
    localparam logic [6:0]  PIN_RESET     = 7'h16;        // Strobes idle high
    // ==========================================
    // Conversion engine states
    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } ssr_conv_t;
endpackage : ssr_pkg

// ==== hw/ssr_sync.sv ====
// Two-flop pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module ssr_sync #(
    parameter int              W         = 1,        // Number of pins
    parameter logic [W-1:0]    RESET_VAL = '0        // Idle pin levels
) (
    input  wire logic          aclk,                 // System clock
    input  wire logic          aresetn,              // Sync reset, active low
    input  wire logic [W-1:0]  din,                  // Raw pins
    output logic      [W-1:0]  level,                // Synchronised level
    output logic      [W-1:0]  rise,                 // One-cycle rise pulse
    output logic      [W-1:0]  fall                  // One-cycle fall pulse
);
    // ==========================================
    // Stages
    logic [W-1:0] meta;   // First stage, read only by stage two
    logic [W-1:0] stab;   // Second stage
    logic [W-1:0] prev;   // Delayed copy for edges

    // Shift chain; edges never look at the first stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= RESET_VAL;
            stab <= RESET_VAL;
            prev <= RESET_VAL;
        end else begin
            meta <= din;
            stab <= meta;
            prev <= stab;
        end
    end

    assign level = stab;
    assign rise  = stab & ~prev;
    assign fall  = ~stab & prev;
endmodule : ssr_sync
`default_nettype wire

// ==== hw/ssr_readout.sv ====
// Slave serial result readout port with AXI4-Lite control
// Behaviour
// - External serial clock when source select high
// - Clock gated by select; drive when strobes low
// - Continuous or idle-high/low clock accepted
// - Select timing picks after or during read
// - New result readable when conversion ends
// - Sixteen bits, MSB first, stable both edges
// - Serial clock up to about 16.7 MHz, each phase at least 3 aclk cycles
// - Chaining only in read-after-conversion mode
// - Chain input sampled on opposite clock edge
// - Previous result readable during conversion
// - Unfinished during-read pulses incomplete flag
// - Serial port only when serial select high
// - Outputs released when select or strobe high
// - Convert start fall runs conversion to end
`timescale 1ns/1ps
`default_nettype none
module ssr_readout (
    input  wire logic        aclk,                   // 100 MHz clock
    input  wire logic        aresetn,                // Sync reset, active low
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,           // Write address
    input  wire logic        s_axi_awvalid,          // Write address valid
    output logic             s_axi_awready,          // Write address ready
    input  wire logic [31:0] s_axi_wdata,            // Write data
    input  wire logic [3:0]  s_axi_wstrb,            // Byte enables
    input  wire logic        s_axi_wvalid,           // Write data valid
    output logic             s_axi_wready,           // Write data ready
    output logic [1:0]       s_axi_bresp,            // Write response
    output logic             s_axi_bvalid,           // Write response valid
    input  wire logic        s_axi_bready,           // Write response ready
    input  wire logic [7:0]  s_axi_araddr,           // Read address
    input  wire logic        s_axi_arvalid,          // Read address valid
    output logic             s_axi_arready,          // Read address ready
    output logic [31:0]      s_axi_rdata,            // Read data
    output logic [1:0]       s_axi_rresp,            // Read response
    output logic             s_axi_rvalid,           // Read data valid
    input  wire logic        s_axi_rready,           // Read data ready
    // Converter pins
    input  wire logic        serial_clk,             // Host serial clock
    input  wire logic        cs_n,                   // Device select, low
    input  wire logic        rd_n,                   // Read strobe, low
    input  wire logic        chain_data_in,          // Upstream chain data
    input  wire logic        convert_start_n,        // Convert start, falling
    input  wire logic        clock_source_select,    // High: external clock
    input  wire logic        serial_parallel_select, // High: serial port
    output logic             conversion_busy,        // Conversion in progress
    output logic             serial_result_out,      // Serial data out
    output logic             serial_result_oe_n,     // Low while driving
    output logic             incomplete_read_flag    // One-cycle pulse
);
    // ==========================================
    // Pin synchronisers
    logic [ssr_pkg::PIN_COUNT-1:0] pin_raw;   // Raw pins
    logic [ssr_pkg::PIN_COUNT-1:0] pin_lvl;   // Synced levels
    logic [ssr_pkg::PIN_COUNT-1:0] pin_rise;  // Synced rises
    logic [ssr_pkg::PIN_COUNT-1:0] pin_fall;  // Synced falls

    assign pin_raw = {serial_parallel_select, clock_source_select, convert_start_n,
                      chain_data_in, rd_n, cs_n, serial_clk};

    ssr_sync #(
        .W         (ssr_pkg::PIN_COUNT),
        .RESET_VAL (ssr_pkg::PIN_RESET)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pin_raw),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // ==========================================
    // Registers and state
    logic        ctrl_enable;     // Engine enable
    logic [15:0] result_reg;      // Result of the running conversion
    logic [15:0] conv_cycles;     // Conversion length in cycles
    logic [15:0] result_q;        // Last completed result
    logic        incomplete;      // Sticky incomplete read
    ssr_pkg::ssr_conv_t conv_state; // Engine state
    logic [15:0] conv_cnt;        // Cycles left
    logic [15:0] shreg;           // Output shift register
    logic [4:0]  bit_cnt;         // Bits shifted, saturates
    logic        chain_bit;       // Chain bit caught on rise
    logic        during;          // Read started during conversion
    logic        sel_q;           // Select seen last cycle

    // ==========================================
    // Port decode
    wire port_on   = pin_lvl[ssr_pkg::PIN_SER]
                   & pin_lvl[ssr_pkg::PIN_EXT];
    wire sel       = port_on & ~pin_lvl[ssr_pkg::PIN_CS_N]; // Clock gate
    wire drv       = sel & ~pin_lvl[ssr_pkg::PIN_RD_N];
    wire sel_start = sel & ~sel_q;                          // Select just asserted
    // Edge detection works for any idle level or a free clock
    // Limit: each serial clock phase must last at least 3 aclk cycles
    wire sck_rise  = sel & pin_rise[ssr_pkg::PIN_SCLK];
    wire sck_fall  = sel & pin_fall[ssr_pkg::PIN_SCLK];
    wire busy      = (conv_state == ssr_pkg::CONV_RUN);
    wire cnv_go    = pin_fall[ssr_pkg::PIN_CNV_N] & ~busy & ctrl_enable;
    wire conv_done = busy & (conv_cnt == 16'h0000);
    wire word_done = (bit_cnt >= ssr_pkg::WORD_BITS);
    // A host that deselects before the last bit has still read too little
    wire rd_short  = conv_done & during & ~word_done;

    // ==========================================
    // Conversion engine
    // A start while running is ignored; a conversion cannot be restarted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_state <= ssr_pkg::CONV_IDLE;
            conv_cnt   <= 16'h0000;
            result_q   <= 16'h0000;
        end else if (cnv_go) begin
            conv_state <= ssr_pkg::CONV_RUN;
            conv_cnt   <= (conv_cycles == 16'h0000) ? 16'h0000 : conv_cycles - 16'h0001;
        end else if (conv_done) begin
            conv_state <= ssr_pkg::CONV_IDLE;
            result_q   <= result_reg;
        end else if (busy) begin
            conv_cnt   <= conv_cnt - 16'h0001;               // Count down
        end
    end

    // ==========================================
    // Serial shifter
    // Load on select, reload at conversion end, shift on falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg     <= 16'h0000;
            bit_cnt   <= 5'h00;
            chain_bit <= 1'b0;
            during    <= 1'b0;
            sel_q     <= 1'b0;
        end else begin
            sel_q <= sel;
            // An unfinished during-read stays pending until the conversion ends
            if (conv_done) begin
                during <= 1'b0;                              // Conversion over
                if (sel) begin
                    shreg   <= result_reg;
                    bit_cnt <= 5'h00;
                end
            end else if (sel_start) begin
                shreg   <= result_q;
                bit_cnt <= 5'h00;
                during  <= busy;
            end else if (sck_fall) begin
                shreg   <= {shreg[14:0], chain_bit};
                if (!word_done) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
            // Chain input caught on the edge opposite the shift edge
            if (sck_rise) begin
                chain_bit <= during ? 1'b0 : pin_lvl[ssr_pkg::PIN_CHAIN];
            end
        end
    end

    // ==========================================
    // Pin outputs, all from flops
    // Data shifts on falling edges, so each bit stands over both; select and conversion end reload it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_busy      <= 1'b0;
            serial_result_out    <= 1'b0;
            serial_result_oe_n   <= 1'b1;
            incomplete_read_flag <= 1'b0;
        end else begin
            conversion_busy      <= (cnv_go | busy) & ~conv_done;
            serial_result_out    <= drv & shreg[15];
            serial_result_oe_n   <= ~drv;
            incomplete_read_flag <= rd_short;
        end
    end

    // ==========================================
    // AXI4-Lite slave
    // Decoding shared by read and write paths
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            ssr_pkg::ADDR_CTRL:   reg_index = 3'h0;
            ssr_pkg::ADDR_RESULT: reg_index = 3'h1;
            ssr_pkg::ADDR_CONV:   reg_index = 3'h2;
            ssr_pkg::ADDR_STATUS: reg_index = 3'h3;
            ssr_pkg::ADDR_LAST:   reg_index = 3'h4;
            default:              reg_index = ssr_pkg::IDX_NONE;
        endcase
    endfunction : reg_index

    // Byte-lane merge for 16-bit fields
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge16

    logic [7:0]  aw_addr;   // Held write address
    logic [31:0] w_data;    // Held write data
    logic [3:0]  w_strb;    // Held byte enables
    logic        aw_full;   // Address held
    logic        w_full;    // Data held

    wire       aw_hs       = s_axi_awvalid & s_axi_awready;
    wire       w_hs        = s_axi_wvalid & s_axi_wready;
    wire       ar_hs       = s_axi_arvalid & s_axi_arready;
    wire       wr_go       = aw_full & w_full & ~s_axi_bvalid;
    wire [2:0] wr_idx      = reg_index(aw_addr);
    wire [2:0] rd_idx      = reg_index(s_axi_araddr);
    wire       next_aw     = ~wr_go & (aw_full | aw_hs);
    wire       next_w      = ~wr_go & (w_full | w_hs);
    wire       next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
    wire       clr_inc     = wr_go & (wr_idx == 3'h3) & w_strb[0]
                           & w_data[ssr_pkg::ST_INCOMPLETE];
    wire [31:0] status_word = {19'h00000, bit_cnt, 4'h0, during, sel, incomplete, busy};
    wire [31:0] rd_word =
        (rd_idx == 3'h0) ? {31'h00000000, ctrl_enable} :
        (rd_idx == 3'h1) ? {16'h0000, result_reg} :
        (rd_idx == 3'h2) ? {16'h0000, conv_cycles} :
        (rd_idx == 3'h3) ? status_word :
        (rd_idx == 3'h4) ? {16'h0000, result_q} : 32'h00000000;

    // Write channel holds address and data until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ssr_pkg::RESP_OKAY;
        end else begin
            aw_full       <= next_aw;
            w_full        <= next_w;
            s_axi_awready <= ~next_aw;
            s_axi_wready  <= ~next_w;
            if (aw_hs) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx == ssr_pkg::IDX_NONE) ? ssr_pkg::RESP_SLVERR
                                                             : ssr_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage; the sticky set wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_enable <= ssr_pkg::CTRL_RESET;
            result_reg  <= 16'h0000;
            conv_cycles <= ssr_pkg::CONV_RESET;
            incomplete  <= 1'b0;
        end else begin
            if (wr_go && wr_idx == 3'h0 && w_strb[0]) begin
                ctrl_enable <= w_data[ssr_pkg::CTRL_ENABLE];
            end
            if (wr_go && wr_idx == 3'h1) begin
                result_reg <= merge16(result_reg, w_data, w_strb);
            end
            if (wr_go && wr_idx == 3'h2) begin
                conv_cycles <= merge16(conv_cycles, w_data, w_strb);
            end
            incomplete <= rd_short | (incomplete & ~clr_inc);
        end
    end

    // Read channel answers one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ssr_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_idx == ssr_pkg::IDX_NONE) ? ssr_pkg::RESP_SLVERR
                                                            : ssr_pkg::RESP_OKAY;
            end
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ext_clock_only:
    assert property (!pin_lvl[ssr_pkg::PIN_EXT] |=> serial_result_oe_n)
        else $error("Port drove without external clock select");

    a_serial_select:
    assert property (!pin_lvl[ssr_pkg::PIN_SER] |=> serial_result_oe_n)
        else $error("Port drove with parallel select");

    a_strobe_release:
    assert property ((pin_lvl[ssr_pkg::PIN_CS_N] | pin_lvl[ssr_pkg::PIN_RD_N])
                     |=> serial_result_oe_n)
        else $error("Output driven while strobe high");

    a_drive_data:
    assert property (drv |=> !serial_result_oe_n && serial_result_out == $past(shreg[15]))
        else $error("Selected port not driving top bit");

    a_busy_hold:
    assert property (cnv_go |=> conversion_busy && busy && conv_cnt == $past(conv_cycles) - 16'h0001
                     || $past(conv_cycles) == 16'h0000)
        else $error("Conversion start not honoured");

    a_new_result:
    assert property (conv_done && sel |=> shreg == $past(result_reg) && bit_cnt == 5'h00)
        else $error("New result not loaded at conversion end");

    a_prev_result:
    assert property (sel_start && busy && !conv_done |=> during && shreg == $past(result_q))
        else $error("Previous result not presented during conversion");

    a_bit_count:
    assert property (sck_fall && !conv_done && !sel_start && !word_done
                     |=> bit_cnt == $past(bit_cnt) + 5'h01 && shreg[15] == $past(shreg[14]))
        else $error("Shift or bit count wrong");

    a_chain_shift:
    assert property (sck_fall && !conv_done && !sel_start |=> shreg[0] == $past(chain_bit))
        else $error("Chain bit not shifted in");

    a_chain_block:
    assert property (sck_rise && during |=> !chain_bit)
        else $error("Chain input used during conversion read");

    a_short_pulse:
    assert property (rd_short |=> incomplete_read_flag ##1 !incomplete_read_flag && incomplete)
        else $error("Incomplete read not flagged");
endmodule : ssr_readout
`default_nettype wire

// ==== tb/ssr_host.sv ====
// Host serial master model for the slave result readout port
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
    input  wire logic serial_result_out,  // Device data
    input  wire logic serial_result_oe_n, // Low while device drives
    output var  logic serial_clk,         // Idles low between frames
    output var  logic cs_n,               // Device select
    output var  logic rd_n,               // Read strobe
    output var  logic chain_data_in       // Upstream converter data
);
    logic line_last = 1'b0; // Last level seen
    // Released line shows no stale value
    wire logic line = serial_result_oe_n ? ~line_last : serial_result_out;
    initial begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        chain_data_in = 1'b0;
    end
    // Set the strobes only, clock stays still
    task automatic sel(input logic c, input logic r);
        #3 cs_n = c;
        rd_n = r;
    endtask : sel
    // One framed transfer of n bits; upstream word shifts on falls
    task automatic xfer(input int n, input logic [31:0] up, output logic [31:0] got);
        logic [31:0] u;
        u = up;
        got = '0;
        chain_data_in = u[31];
        #3 cs_n = 1'b0;
        rd_n = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b1; // Sample on rise, polarity 0 phase 0
            line_last = line;
            got = {got[30:0], line};
            #62.5 serial_clk = 1'b0;
            u = u << 1;
            chain_data_in = u[31]; // Upstream moves on our shift edge
            #62.5;
        end
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask : xfer
endmodule : ssr_host
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the serial result readout port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("unexpected %0t: %h not %h", $time, g, e); end end
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, cnv_n = 1'b1, ser_sel = 1'b1, ext_sel = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;           // AXI addresses
    logic [31:0] wdata = 32'h0, rdata, got;                // Data words
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, sclk, cs_n, rd_n, chain;
    logic        busy, sdo, oe_n, flag;                    // Converter pins
    logic [1:0]  bresp, rresp;                             // Responses
    int          fail_count = 0, checks_done = 0, flags = 0, bcnt = 0;
    ssr_readout ssr_readout_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_clk(sclk), .cs_n(cs_n), .rd_n(rd_n),
        .chain_data_in(chain), .convert_start_n(cnv_n), .clock_source_select(ext_sel),
        .serial_parallel_select(ser_sel), .conversion_busy(busy), .serial_result_out(sdo),
        .serial_result_oe_n(oe_n), .incomplete_read_flag(flag));
    ssr_host ssr_host_i (.serial_result_out(sdo), .serial_result_oe_n(oe_n),
        .serial_clk(sclk), .cs_n(cs_n), .rd_n(rd_n), .chain_data_in(chain));
    // ==========================================
    // Clock and event monitors
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (busy) bcnt++;
        if (flag) flags++;
    end
    // ==========================================
    // AXI4-Lite master tasks; waits bounded
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        `CHK({bvalid, bresp}, {1'b1, e})
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [1:0] e, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        `CHK({rvalid, rresp}, {1'b1, e})
    endtask : axr
    // Convert start pulse, then conversion must be running
    task automatic start;
        @(posedge aclk);
        cnv_n <= 1'b0; // One shared convert start
        bcnt = 0;
        repeat (6) @(posedge aclk);
        cnv_n <= 1'b1;
        `CHK(busy, 1'b1)
    endtask : start
    task automatic finish(input int len);
        for (int i = 0; i < 2000 && busy; i++) @(posedge aclk);
        repeat (2) @(posedge aclk); // Let the flag monitor count the end pulse
        `CHK(bcnt, len)
    endtask : finish
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // Scenarios
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        axr(ssr_pkg::ADDR_CONV, ssr_pkg::RESP_OKAY, got);
        `CHK(got, 32'(ssr_pkg::CONV_RESET))
        axr(8'h14, ssr_pkg::RESP_SLVERR, got);
        axw(8'h18, 32'hffff, ssr_pkg::RESP_SLVERR);
        // Port must stay released unless fully enabled
        ser_sel <= 1'b0;
        host_sel_chk(1'b0, 1'b0);
        ser_sel <= 1'b1;
        ext_sel <= 1'b0;
        host_sel_chk(1'b0, 1'b0);
        ext_sel <= 1'b1;
        host_sel_chk(1'b0, 1'b1);
        host_sel_chk(1'b1, 1'b0);
        // Read after conversion with an upstream word chained behind
        axw(ssr_pkg::ADDR_RESULT, 32'ha5c3, ssr_pkg::RESP_OKAY);
        start();
        finish(400);
        axr(ssr_pkg::ADDR_LAST, ssr_pkg::RESP_OKAY, got);
        `CHK(got, 32'ha5c3)
        host_i_xfer(32, 32'h96e1_0000); // Clock only while idle
        `CHK(got, 32'ha5c3_96e1)
        // Short read during conversion must be flagged; chain input tied high
        axw(ssr_pkg::ADDR_RESULT, 32'h3c96, ssr_pkg::RESP_OKAY);
        start();
        host_i_xfer(8, 32'hffff_ffff); // One byte, then deselect
        `CHK(got[7:0], 8'ha5)
        finish(400);
        `CHK(flags, 1)
        axr(ssr_pkg::ADDR_STATUS, ssr_pkg::RESP_OKAY, got);
        `CHK(got[ssr_pkg::ST_INCOMPLETE], 1'b1)
        axw(ssr_pkg::ADDR_STATUS, 32'h1 << ssr_pkg::ST_INCOMPLETE, ssr_pkg::RESP_OKAY);
        // Full read during conversion raises nothing
        start();
        host_i_xfer(16, 32'hffff_ffff); // All bits early in conversion
        `CHK(got[15:0], 16'h3c96)
        finish(400);
        `CHK(flags, 1)
        axr(ssr_pkg::ADDR_STATUS, ssr_pkg::RESP_OKAY, got);
        `CHK(got[ssr_pkg::ST_INCOMPLETE], 1'b0)
        print_verdict();
    end
    // Strobe levels given, output must stay released
    task automatic host_sel_chk(input logic c, input logic r);
        ssr_host_i.sel(c, r);
        repeat (10) @(posedge aclk);
        `CHK(oe_n, 1'b1)
        ssr_host_i.sel(1'b1, 1'b1);
    endtask : host_sel_chk
    task automatic host_i_xfer(input int n, input logic [31:0] up);
        ssr_host_i.xfer(n, up, got);
        repeat (4) @(posedge aclk);
    endtask : host_i_xfer
    // Watchdog well beyond the expected run
    initial begin
        #300000;
        fail_count++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
